// file: pkg/tmw_pkg.sv
// Package: register map, field positions and timing for the timer/watchdog block
package tmw_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  // Register offsets
  localparam logic [2:0] OFS_CTRL = 3'h0;
  localparam logic [2:0] OFS_TIMER = 3'h1;
  localparam logic [2:0] OFS_WDCTRL = 3'h2;
  localparam logic [2:0] OFS_MASK2 = 3'h3;
  localparam logic [2:0] OFS_MASK1 = 3'h4;
  localparam logic [2:0] OFS_PEND = 3'h5;
  localparam logic [2:0] OFS_CMD = 3'h6;
  localparam logic [2:0] OFS_AUX = 3'h7;
  // Control register fields
  localparam int CT_EXT_EDGE = 7;
  localparam int CT_GATE = 6;
  localparam int CT_SRC = 5;
  localparam int CT_EDGE = 4;
  localparam int CT_PSE = 3;
  // Watchdog control fields
  localparam int WD_EN = 7;
  localparam int WD_EXTSEL = 6;
  localparam int WD_PSE = 3;
  // Interrupt bit positions, shared by masks and pending flags
  localparam int IRQ_TMR = 0;
  localparam int IRQ_CHG = 1;
  localparam int IRQ_EXT = 2;
  localparam int IRQ_T1 = 3;
  localparam int IRQ_T3 = 5;
  localparam int IRQ_ADC = 6;
  localparam logic [7:0] MASK1_USED = 8'h47;
  localparam logic [7:0] MASK2_USED = 8'h28;
  localparam logic [7:0] CTRL_WMASK = 8'hBF;
  localparam logic [7:0] WDCTRL_USED = 8'hCF;
  // Command bits (write-only strobes)
  localparam int CMD_GON = 0;
  localparam int CMD_GOFF = 1;
  localparam int CMD_WCLR = 2;
  localparam int CMD_SLEEP = 3;
  localparam int CMD_WAKE = 4;
  // Auxiliary register fields
  localparam int AUX_SLEEP = 0;
  localparam int AUX_WDTO = 1;
  localparam int AUX_CLKSEL = 6;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  // Watchdog period with no prescaler
  localparam int WDT_PERIOD_US = 16500;
  localparam int CLK_MHZ = 10;
  localparam int WDT_CYCLES = WDT_PERIOD_US * CLK_MHZ;
  // Register bus request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic we;
    logic re;
  } tmw_bus_t;
endpackage

// file: rtl/tmw_top.sv
// Timer/counter, watchdog, two prescalers and interrupt masks with register port
//
// Contract
// - Mask two: bit 5 enables timer 3, bit 3 timer 1; rest read zero.
// - Mask one bit 6 enables the ADC-complete interrupt.
// - Mask one bit 2 enables the external-pin interrupt.
// - External comparison value resets to zero; rising edge on high pin fires.
// - Mask one bit 1 enables the input-change interrupt.
// - Mask one bit 0 enables timer overflow; bits 7, 5..3 read zero.
// - Global gate above masks, opened and closed by instructions.
// - Two separate 8-bit prescalers, one per timer.
// - Three-bit ratio fields in control and watchdog control registers.
// - Each write to the main timer clears its prescaler.
// - Watchdog clear and sleep clear watchdog counter and prescaler.
// - Main timer is 8-bit, increments per base clock without prescale.
// - Timer clock select bit chooses the base clock.
// - External source counts selected edges on the timer pin.
// - Main timer stops in sleep.
// - Watchdog keeps counting in sleep.
// - Enabled watchdog time-out resets the device.
// - Watchdog enable bit may change any time in normal mode.
// - Unscaled watchdog time-out is about 16.5 ms.
// - Prescale ratios 1:2 at 000 up to 1:256 at 111; off gives 1:1.
// - Source select 0 is internal clock, 1 is the timer pin.
// - Edge select 0 counts rising, 1 counts falling edges.
// - Watchdog control bit 7 enables the watchdog.
`timescale 1ns/1ps
module tmw_top #(
  parameter int WDT_CYCLES = tmw_pkg::WDT_CYCLES
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire tmw_pkg::tmw_bus_t bus_i,
  output logic [7:0] rdata_o,
  input wire logic fc_main_tick_i,
  input wire logic fc_sub_tick_i,
  input wire logic timer_pin_i,
  input wire logic ext_pin_i,
  input wire logic adc_done_i,
  input wire logic input_change_i,
  input wire logic timer1_event_i,
  input wire logic timer3_event_i,
  output logic irq_o,
  output logic sleep_o,
  output logic wdt_reset_o
);

  //////////////////////////////////////////////////////////////////////////////
  // Elaboration check
  generate
    if (WDT_CYCLES < 2) begin : g_bad_wdt
      $error("WDT_CYCLES must be at least 2");
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0] ctrl_reg;
  logic [7:0] timer_reg;
  logic [7:0] wdctrl_reg;
  logic [7:0] mask2_reg;
  logic [7:0] mask1_reg;
  logic [7:0] pend_reg;
  logic [7:0] pend_next;
  logic [7:0] tpre_reg;
  logic [7:0] wpre_reg;
  logic [31:0] wcnt_reg;
  logic gate_reg;
  logic sleep_reg;
  logic wdto_reg;
  logic clksel_reg;
  logic tpin_prev_reg;
  logic ext_cmp_reg;
  logic wr_timer;
  logic wr_cmd;
  logic base_tick;
  logic pin_edge;
  logic src_tick;
  logic timer_tick;
  logic wdt_tick;
  logic wdt_clear;
  logic wdt_expire;
  logic ext_hit;
  logic [7:0] tpre_mask;
  logic [7:0] wpre_mask;
  logic [7:0] rd_mux;

  //////////////////////////////////////////////////////////////////////////////
  // Write decode
  assign wr_timer = bus_i.we && (bus_i.addr == tmw_pkg::OFS_TIMER);
  assign wr_cmd = bus_i.we && (bus_i.addr == tmw_pkg::OFS_CMD);

  // Control register; gate bit is only a mirror of the global gate
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_reg <= tmw_pkg::RST_BYTE;
    end else if (ce_i && bus_i.we && bus_i.addr == tmw_pkg::OFS_CTRL) begin
      ctrl_reg <= bus_i.wdata & tmw_pkg::CTRL_WMASK;
    end
  end

  // Watchdog control; writable any time so software can toggle enable
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wdctrl_reg <= tmw_pkg::RST_BYTE;
    end else if (ce_i && bus_i.we && bus_i.addr == tmw_pkg::OFS_WDCTRL) begin
      wdctrl_reg <= bus_i.wdata & tmw_pkg::WDCTRL_USED;
    end
  end

  // Mask registers; unused bits never store so they read zero
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      mask2_reg <= tmw_pkg::RST_BYTE;
      mask1_reg <= tmw_pkg::RST_BYTE;
    end else if (ce_i && bus_i.we) begin
      if (bus_i.addr == tmw_pkg::OFS_MASK2) begin
        mask2_reg <= bus_i.wdata & tmw_pkg::MASK2_USED;
      end
      if (bus_i.addr == tmw_pkg::OFS_MASK1) begin
        mask1_reg <= bus_i.wdata & tmw_pkg::MASK1_USED;
      end
    end
  end

  // Auxiliary: base clock select
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      clksel_reg <= 1'b0;
    end else if (ce_i && bus_i.we && bus_i.addr == tmw_pkg::OFS_AUX) begin
      clksel_reg <= bus_i.wdata[tmw_pkg::AUX_CLKSEL];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Global gate, opened and closed by instruction strobes
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      gate_reg <= 1'b0;
    end else if (ce_i && wr_cmd) begin
      if (bus_i.wdata[tmw_pkg::CMD_GOFF]) begin
        gate_reg <= 1'b0;
      end else if (bus_i.wdata[tmw_pkg::CMD_GON]) begin
        gate_reg <= 1'b1;
      end
    end
  end

  // Sleep state; left by a wake command or an enabled pending event
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sleep_reg <= 1'b0;
    end else if (ce_i) begin
      if (wr_cmd && bus_i.wdata[tmw_pkg::CMD_SLEEP]) begin
        sleep_reg <= 1'b1;
      end else if ((wr_cmd && bus_i.wdata[tmw_pkg::CMD_WAKE]) ||
                   (|(pend_reg & (mask1_reg | mask2_reg)))) begin
        sleep_reg <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Main timer source: base clock, or sampled pin edge
  assign base_tick = clksel_reg ? fc_sub_tick_i : fc_main_tick_i;
  // Pin assumed stable over more than one clock, so one sample per level is seen
  assign pin_edge = ctrl_reg[tmw_pkg::CT_EDGE] ?
                    (tpin_prev_reg && !timer_pin_i) :
                    (!tpin_prev_reg && timer_pin_i);
  assign src_tick = ctrl_reg[tmw_pkg::CT_SRC] ? pin_edge : base_tick;

  // Pin history for edge detection
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      tpin_prev_reg <= 1'b0;
    end else if (ce_i) begin
      tpin_prev_reg <= timer_pin_i;
    end
  end

  // Prescale tap: low ratio+1 bits all ones gives 2^(ratio+1) division
  assign tpre_mask = 8'(9'h002 << ctrl_reg[2:0]) - 8'h01;
  assign timer_tick = src_tick && (!ctrl_reg[tmw_pkg::CT_PSE] ||
                      ((tpre_reg & tpre_mask) == tpre_mask));

  // Timer prescaler, frozen in sleep, cleared by timer writes
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      tpre_reg <= 8'h00;
    end else if (ce_i) begin
      if (wr_timer) begin
        tpre_reg <= 8'h00;
      end else if (src_tick && !sleep_reg) begin
        tpre_reg <= tpre_reg + 8'h01;
      end
    end
  end

  // Main timer counter; software write takes priority over a tick
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      timer_reg <= 8'h00;
    end else if (ce_i) begin
      if (wr_timer) begin
        timer_reg <= bus_i.wdata;
      end else if (timer_tick && !sleep_reg) begin
        timer_reg <= timer_reg + 8'h01;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // External pin edge against comparison value that starts at zero
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ext_cmp_reg <= 1'b0;
    end else if (ce_i && wdctrl_reg[tmw_pkg::WD_EXTSEL]) begin
      ext_cmp_reg <= ext_pin_i;
    end
  end

  // Pin path masked until function select is set
  assign ext_hit = wdctrl_reg[tmw_pkg::WD_EXTSEL] && (ctrl_reg[tmw_pkg::CT_EXT_EDGE] ?
                   (ext_cmp_reg && !ext_pin_i) : (!ext_cmp_reg && ext_pin_i));

  //////////////////////////////////////////////////////////////////////////////
  // Pending flags: event sets win over write-one-to-clear
  always_comb begin
    pend_next = pend_reg;
    if (bus_i.we && bus_i.addr == tmw_pkg::OFS_PEND) begin
      pend_next = pend_reg & ~bus_i.wdata;
    end
    if (timer_tick && !sleep_reg && !wr_timer && timer_reg == 8'hFF) begin
      pend_next[tmw_pkg::IRQ_TMR] = 1'b1;
    end
    if (input_change_i) begin
      pend_next[tmw_pkg::IRQ_CHG] = 1'b1;
    end
    if (ext_hit) begin
      pend_next[tmw_pkg::IRQ_EXT] = 1'b1;
    end
    if (timer1_event_i) begin
      pend_next[tmw_pkg::IRQ_T1] = 1'b1;
    end
    if (timer3_event_i) begin
      pend_next[tmw_pkg::IRQ_T3] = 1'b1;
    end
    if (adc_done_i) begin
      pend_next[tmw_pkg::IRQ_ADC] = 1'b1;
    end
  end

  // Flag storage
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pend_reg <= 8'h00;
    end else if (ce_i) begin
      pend_reg <= pend_next;
    end
  end

  // Interrupt request: masks positions do not overlap, so OR them
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= gate_reg && (|(pend_next & (mask1_reg | mask2_reg)));
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Watchdog: one clock stands in for the free-running RC oscillator
  assign wdt_clear = wr_cmd && (bus_i.wdata[tmw_pkg::CMD_WCLR] ||
                     bus_i.wdata[tmw_pkg::CMD_SLEEP]);
  assign wpre_mask = 8'(9'h002 << wdctrl_reg[2:0]) - 8'h01;
  assign wdt_tick = !wdctrl_reg[tmw_pkg::WD_PSE] ||
                    ((wpre_reg & wpre_mask) == wpre_mask);
  assign wdt_expire = wdctrl_reg[tmw_pkg::WD_EN] && wdt_tick &&
                      (wcnt_reg == 32'(WDT_CYCLES - 1));

  // Watchdog prescaler; not gated by sleep
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wpre_reg <= 8'h00;
    end else if (ce_i) begin
      if (wdt_clear || !wdctrl_reg[tmw_pkg::WD_EN]) begin
        wpre_reg <= 8'h00;
      end else begin
        wpre_reg <= wpre_reg + 8'h01;
      end
    end
  end

  // Watchdog counter; restarts after a time-out
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wcnt_reg <= 32'h0000_0000;
    end else if (ce_i) begin
      if (wdt_clear || wdt_expire || !wdctrl_reg[tmw_pkg::WD_EN]) begin
        wcnt_reg <= 32'h0000_0000;
      end else if (wdt_tick) begin
        wcnt_reg <= wcnt_reg + 32'h0000_0001;
      end
    end
  end

  // Reset request pulse and sticky time-out status
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wdt_reset_o <= 1'b0;
      wdto_reg <= 1'b0;
    end else if (ce_i) begin
      wdt_reset_o <= wdt_expire;
      if (wdt_expire) begin
        wdto_reg <= 1'b1;
      end else if (bus_i.we && bus_i.addr == tmw_pkg::OFS_AUX &&
                   bus_i.wdata[tmw_pkg::AUX_WDTO]) begin
        wdto_reg <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read mux; command register reads as zero
  always_comb begin
    rd_mux = 8'h00;
    unique case (bus_i.addr)
      tmw_pkg::OFS_CTRL: begin
        rd_mux = ctrl_reg;
        rd_mux[tmw_pkg::CT_GATE] = gate_reg;
      end
      tmw_pkg::OFS_TIMER: rd_mux = timer_reg;
      tmw_pkg::OFS_WDCTRL: rd_mux = wdctrl_reg;
      tmw_pkg::OFS_MASK2: rd_mux = mask2_reg;
      tmw_pkg::OFS_MASK1: rd_mux = mask1_reg;
      tmw_pkg::OFS_PEND: rd_mux = pend_reg;
      tmw_pkg::OFS_CMD: rd_mux = 8'h00;
      tmw_pkg::OFS_AUX: begin
        rd_mux[tmw_pkg::AUX_SLEEP] = sleep_reg;
        rd_mux[tmw_pkg::AUX_WDTO] = wdto_reg;
        rd_mux[tmw_pkg::AUX_CLKSEL] = clksel_reg;
      end
    endcase
  end

  // Read data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (ce_i) begin
      rdata_o <= bus_i.re ? rd_mux : 8'h00;
    end
  end

  // Sleep indication
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sleep_o <= 1'b0;
    end else if (ce_i) begin
      sleep_o <= sleep_reg;
    end
  end

endmodule

// file: testbench/tmw_checker.sv
// Checker: port relations of the timer, interrupt and watchdog block
`timescale 1ns/1ps
module tmw_checker #(
  parameter int WDT_CYCLES = tmw_pkg::WDT_CYCLES
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire tmw_pkg::tmw_bus_t bus_i,
  input wire logic [7:0] rdata_o,
  input wire logic irq_o,
  input wire logic sleep_o,
  input wire logic wdt_reset_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  logic wd_en_reg;
  int gap_reg;
  wire logic cmd_wr = ce_i && bus_i.we && bus_i.addr == tmw_pkg::OFS_CMD;
  wire logic rd_hit = ce_i && bus_i.re;
  ////////////////////////////////////////////////////////////
  // Shadow of the watchdog enable, taken from bus writes
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wd_en_reg <= 1'b0;
    end else if (ce_i && bus_i.we && bus_i.addr == tmw_pkg::OFS_WDCTRL) begin
      wd_en_reg <= bus_i.wdata[tmw_pkg::WD_EN];
    end
  end
  // Cycles since the last time-out; saturates so it never wraps
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      gap_reg <= 0;
    end else if (wdt_reset_o) begin
      gap_reg <= 0;
    end else if (gap_reg < 100000) begin
      gap_reg <= gap_reg + 1;
    end
  end
  ////////////////////////////////////////////////////////////
  a_rdata_idle: assert property ($past(ce_i) && !$past(rd_hit) |-> rdata_o == 8'h00)
    else $error("read data not zero outside a read");
  a_mask_one_bits: assert property ($past(rd_hit && bus_i.addr == tmw_pkg::OFS_MASK1) |->
    (rdata_o & ~tmw_pkg::MASK1_USED) == 8'h00) else $error("unused mask one bit set");
  a_mask_two_bits: assert property ($past(rd_hit && bus_i.addr == tmw_pkg::OFS_MASK2) |->
    (rdata_o & ~tmw_pkg::MASK2_USED) == 8'h00) else $error("unused mask two bit set");
  a_cmd_reads_zero: assert property ($past(rd_hit && bus_i.addr == tmw_pkg::OFS_CMD) |-> rdata_o == 8'h00)
    else $error("command register read not zero");
  a_gate_off_quiet: assert property (cmd_wr && bus_i.wdata[tmw_pkg::CMD_GOFF] ##1
    !(cmd_wr && bus_i.wdata[tmw_pkg::CMD_GON]) |=> !irq_o) else $error("irq with gate closed");
  a_wdt_pulse_one: assert property (wdt_reset_o |=> !wdt_reset_o)
    else $error("time-out pulse longer than one cycle");
  a_wdt_off_quiet: assert property (!wd_en_reg [*2] |=> !wdt_reset_o)
    else $error("time-out while watchdog disabled");
  a_wdt_period_min: assert property (wdt_reset_o |-> gap_reg >= WDT_CYCLES - 1)
    else $error("time-out pulses too close");
  // Main scenarios reached
  c_irq: cover property (irq_o);
  c_sleep: cover property (sleep_o);
  c_wdt: cover property (wdt_reset_o);
endmodule

bind tmw_top tmw_checker #(.WDT_CYCLES(WDT_CYCLES)) u_chk (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i),
  .bus_i(bus_i), .rdata_o(rdata_o), .irq_o(irq_o), .sleep_o(sleep_o), .wdt_reset_o(wdt_reset_o));

// file: testbench/tmw_pin_drv.sv
// Partner model: external driver of the timer input pin
`timescale 1ns/1ps
module tmw_pin_drv (
  input wire logic mclk_i,
  input wire logic start_i,
  input wire logic [3:0] edges_i,
  output logic pin_o,
  output logic busy_o
);
  logic [3:0] left_reg = 4'h0;
  logic hold_reg = 1'b0;
  logic pin_reg = 1'b0;
  assign pin_o = pin_reg;
  assign busy_o = left_reg != 4'h0;
  // Each level stays two clocks, so no edge is too short to see
  always_ff @(posedge mclk_i) begin
    if (start_i) begin
      left_reg <= edges_i;
    end else if (busy_o) begin
      hold_reg <= ~hold_reg;
      if (hold_reg) begin
        pin_reg <= ~pin_reg;
        left_reg <= left_reg - 4'h1;
      end
    end
  end
endmodule

// file: testbench/tb.sv
// Testbench: register sequences for timer, masks, interrupts and watchdog
`timescale 1ns/1ps
module tb;
  localparam int WDT = 8;
  localparam logic [2:0] CT = tmw_pkg::OFS_CTRL, TM = tmw_pkg::OFS_TIMER, WC = tmw_pkg::OFS_WDCTRL;
  localparam logic [2:0] M2 = tmw_pkg::OFS_MASK2, M1 = tmw_pkg::OFS_MASK1, PD = tmw_pkg::OFS_PEND;
  localparam logic [2:0] CM = tmw_pkg::OFS_CMD, AX = tmw_pkg::OFS_AUX;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  tmw_pkg::tmw_bus_t bus = '0;
  logic fcm = 1'b0;
  logic fcs = 1'b0;
  logic ext = 1'b0;
  logic ce = 1'b1;
  logic start = 1'b0;
  logic [3:0] ev = 4'h0;
  logic [3:0] ne = 4'h0;
  logic [7:0] rdata;
  logic pin, busy, irq, slp, wdr;
  logic [2:0] ma [4] = '{M1, M1, M2, M2};
  logic [7:0] mb [4] = '{8'h40, 8'h02, 8'h08, 8'h20};
  int miscompares = 0;
  int checks_done = 0;
  int cyc = 0;
  int k;

  tmw_top #(.WDT_CYCLES(WDT)) u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce), .bus_i(bus), .rdata_o(rdata),
    .fc_main_tick_i(fcm), .fc_sub_tick_i(fcs), .timer_pin_i(pin), .ext_pin_i(ext), .adc_done_i(ev[0]),
    .input_change_i(ev[1]), .timer1_event_i(ev[2]), .timer3_event_i(ev[3]), .irq_o(irq), .sleep_o(slp),
    .wdt_reset_o(wdr));
  tmw_pin_drv u_pin (.mclk_i(mclk_i), .start_i(start), .edges_i(ne), .pin_o(pin), .busy_o(busy));

  always #50 mclk_i = ~mclk_i;
  // Cut a hang short; the whole run needs far fewer cycles
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      stop_test();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (miscompares == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge mclk_i);
    bus <= '0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string nm);
    @(posedge mclk_i);
    bus <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
    @(posedge mclk_i);
    bus <= '0;
    #1 chk(nm, rdata, exp);
  endtask
  task automatic tick(input int n, input logic sub);
    repeat (n) begin
      @(posedge mclk_i);
      fcm <= !sub;
      fcs <= sub;
      @(posedge mclk_i);
      fcm <= 1'b0;
      fcs <= 1'b0;
    end
  endtask
  task automatic evt(input int i);
    @(posedge mclk_i);
    ev[i] <= 1'b1;
    @(posedge mclk_i);
    ev <= 4'h0;
  endtask
  task automatic irqc(input logic exp);
    @(posedge mclk_i);
    #1 chk("irq", {7'h0, irq}, {7'h0, exp});
  endtask
  // Pin edges come from the partner; extra clocks cover the input sync
  task automatic go(input logic [3:0] n);
    @(posedge mclk_i);
    start <= 1'b1;
    ne <= n;
    @(posedge mclk_i);
    start <= 1'b0;
    #1;
    while (busy) @(posedge mclk_i);
    repeat (4) @(posedge mclk_i);
  endtask
  task automatic wt();
    k = 0;
    do begin
      @(posedge mclk_i);
      #1 k++;
    end while (wdr !== 1'b1 && k < 200);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge mclk_i);
    rst_i <= 1'b0;
    for (int a = 0; a < 8; a++) begin
      rd(3'(a), 8'h00, "reset value");
    end
    wr(M1, 8'hFF);
    rd(M1, 8'h47, "mask one");
    wr(M2, 8'hFF);
    rd(M2, 8'h28, "mask two");
    wr(M1, 8'h00);
    wr(M2, 8'h00);
    wr(CM, 8'h01);
    // Each source waits pending until its own mask bit opens
    for (int i = 0; i < 4; i++) begin
      evt(i);
      irqc(1'b0);
      wr(ma[i], mb[i]);
      irqc(1'b1);
      wr(ma[i], 8'h00);
      wr(PD, 8'hFF);
    end
    wr(TM, 8'hFE);
    tick(2, 1'b0);
    rd(TM, 8'h00, "timer wrap");
    rd(PD, 8'h01, "overflow flag");
    wr(M1, 8'h01);
    irqc(1'b1);
    wr(CM, 8'h02);
    irqc(1'b0);
    wr(M1, 8'h00);
    wr(PD, 8'hFF);
    wr(TM, 8'h10);
    tick(5, 1'b0);
    rd(TM, 8'h15, "count");
    // Enable low must swallow base clock ticks
    @(posedge mclk_i);
    ce <= 1'b0;
    tick(2, 1'b0);
    ce <= 1'b1;
    rd(TM, 8'h15, "enable low");
    wr(AX, 8'h40);
    tick(3, 1'b0);
    tick(2, 1'b1);
    rd(TM, 8'h17, "clock select");
    wr(AX, 8'h00);
    // Every ratio; the stale prescaler would tick early without the clear
    for (int r = 0; r < 8; r++) begin
      wr(CT, 8'h08 | 8'(r));
      wr(TM, 8'h00);
      tick((2 << r) - 1, 1'b0);
      rd(TM, 8'h00, "prescale early");
      tick(1, 1'b0);
      rd(TM, 8'h01, "prescale");
    end
    wr(CT, 8'h20);
    wr(TM, 8'h00);
    go(4'h3);
    rd(TM, 8'h02, "rising edges");
    wr(CT, 8'h30);
    go(4'h3);
    rd(TM, 8'h04, "falling edges");
    // Enable first, then route the pin while it is already high
    wr(CT, 8'h00);
    wr(M1, 8'h04);
    wr(CM, 8'h01);
    ext <= 1'b1;
    wr(WC, 8'h40);
    irqc(1'b1);
    rd(PD, 8'h04, "pin flag");
    // Falling mode: dropping the pin against a stored high fires
    wr(PD, 8'hFF);
    wr(CT, 8'h80);
    ext <= 1'b0;
    rd(PD, 8'h04, "pin falling");
    wr(WC, 8'h00);
    wr(M1, 8'h00);
    wr(PD, 8'hFF);
    wr(TM, 8'h33);
    wr(CM, 8'h08);
    @(posedge mclk_i);
    #1 chk("sleep", {7'h0, slp}, 8'h01);
    tick(4, 1'b0);
    wr(CM, 8'h10);
    rd(TM, 8'h33, "timer in sleep");
    chk("wake", {7'h0, slp}, 8'h00);
    // Watchdog period, clear, sleep, prescale and disable
    wr(WC, 8'h80);
    wt();
    wt();
    chk("wdt period", {7'h0, k >= WDT && k <= WDT + 1}, 8'h01);
    repeat (3) @(posedge mclk_i);
    wr(CM, 8'h04);
    wt();
    chk("wdt clear", {7'h0, k >= WDT - 1}, 8'h01);
    wr(CM, 8'h08);
    wt();
    chk("wdt in sleep", {7'h0, k >= WDT - 1 && k <= WDT + 2}, 8'h01);
    wr(CM, 8'h10);
    wr(WC, 8'h88);
    wt();
    wt();
    chk("wdt prescale", {7'h0, k >= 2 * WDT - 1 && k <= 2 * WDT + 1}, 8'h01);
    wr(WC, 8'h00);
    wt();
    chk("wdt off", 8'(k), 8'hC8);
    rd(AX, 8'h02, "timeout sticky");
    wr(AX, 8'h02);
    rd(AX, 8'h00, "timeout clear");
    stop_test();
  end
endmodule
